// file: rtl/ccr_defines.svh
// Offsets, field positions and reset values of the core register file
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
`define CCR_OFF_STACK 8'h81
`define CCR_OFF_FLAGS 8'hD0
`define CCR_OFF_MAIN 8'hE0
`define CCR_OFF_AUX 8'hF0
`define CCR_RST_VAL 8'h00
`define CCR_BIT_CY 7
`define CCR_BIT_AC 6
`define CCR_BIT_F0 5
`define CCR_BIT_RS1 4
`define CCR_BIT_RS0 3
`define CCR_BIT_OV 2
`define CCR_BIT_UD 1
`define CCR_BIT_P 0
`define CCR_BANK_SHIFT 3
`endif

// file: rtl/ccr_pkg.sv
// Types shared by the core register file modules
package ccr_pkg;
  typedef logic [7:0] ccr_byte_t;
  typedef enum logic [2:0] {
    CCR_OP_NONE = 3'h0,
    CCR_OP_ALU = 3'h1,
    CCR_OP_MULDIV = 3'h3,
    CCR_OP_PUSH = 3'h2,
    CCR_OP_POP = 3'h6,
    CCR_OP_BIT = 3'h7
  } ccr_op_t;
  typedef enum logic [1:0] {
    CCR_ST_IDLE = 2'h0,
    CCR_ST_POP_WAIT = 2'h1,
    CCR_ST_POP_DONE = 2'h3
  } ccr_state_t;
endpackage : ccr_pkg

// file: rtl/ccr_stack_if.sv
// Stack memory port between the register file and its stack engine
`timescale 1ns/1ps
`default_nettype none
interface ccr_stack_if;
  logic push;
  logic pop;
  logic [7:0] sp;
  logic [7:0] wdata;
  logic mem_we;
  logic mem_re;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic sp_inc;
  logic sp_dec;
  logic pop_valid;
  modport core (output push, pop, sp, wdata,
    input mem_we, mem_re, mem_addr, mem_wdata, sp_inc, sp_dec, pop_valid);
  modport eng (input push, pop, sp, wdata,
    output mem_we, mem_re, mem_addr, mem_wdata, sp_inc, sp_dec, pop_valid);
endinterface : ccr_stack_if
`default_nettype wire

// file: rtl/ccr_stack_eng.sv
// Stack engine: addresses internal data memory for push and pop
`timescale 1ns/1ps
`default_nettype none
module ccr_stack_eng (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core side
  ccr_stack_if.eng st
);
  ccr_pkg::ccr_state_t state_reg;

  function automatic logic [7:0] sp_plus1(input logic [7:0] v);
    sp_plus1 = v + 8'h01;
  endfunction : sp_plus1

  // Push writes above the pointer; pop reads at it
  assign st.mem_we = st.push && state_reg == ccr_pkg::CCR_ST_IDLE;
  assign st.mem_re = st.pop && state_reg == ccr_pkg::CCR_ST_IDLE;
  assign st.mem_addr = st.push ? sp_plus1(st.sp) : st.sp;
  assign st.mem_wdata = st.wdata;
  assign st.sp_inc = st.mem_we;
  assign st.sp_dec = state_reg == ccr_pkg::CCR_ST_POP_WAIT;
  assign st.pop_valid = state_reg == ccr_pkg::CCR_ST_POP_WAIT;

  // Memory read has one cycle latency, so decrement follows the read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ccr_pkg::CCR_ST_IDLE;
    end else begin
      case (state_reg)
        ccr_pkg::CCR_ST_IDLE: begin
          if (st.mem_re) begin
            state_reg <= ccr_pkg::CCR_ST_POP_WAIT;
          end
        end
        ccr_pkg::CCR_ST_POP_WAIT: begin
          state_reg <= ccr_pkg::CCR_ST_POP_DONE;
        end
        ccr_pkg::CCR_ST_POP_DONE: begin
          state_reg <= ccr_pkg::CCR_ST_IDLE;
        end
        default: begin
          state_reg <= ccr_pkg::CCR_ST_IDLE;
        end
      endcase
    end
  end

  pop_spacing_a: assert property (@(posedge clk) disable iff (rst)
    st.mem_re |=> st.sp_dec)
    else $error("pop did not decrement next cycle");
endmodule : ccr_stack_eng
`default_nettype wire

// file: rtl/ccr_core_regs.sv
// Accumulator, auxiliary, flags and stack pointer register file
// Operation
// - Accumulator at 0xE0, read/write, resets zero
// - Datapath reads and writes accumulator directly
// - Accumulator bits individually set, cleared, tested
// - Auxiliary register at 0xF0, resets zero
// - Auxiliary register feeds multiply and divide
// - Auxiliary register is free temporary storage
// - Auxiliary register bits individually addressable
// - Flags at 0xD0, fixed bit layout, reset zero
// - Half-carry records low nibble carry out
// - User flag changes only by software
// - Stack pointer at 0x81, resets zero
// - Push stores at pointer plus one
// - Pop reads at current pointer
// - Standard stack spans 256-byte internal memory
`include "ccr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ccr_core_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Datapath operation
  input wire ccr_pkg::ccr_op_t dp_op,
  input wire logic [7:0] dp_main_wdata,
  input wire logic dp_main_we,
  input wire logic [7:0] dp_aux_wdata,
  input wire logic dp_aux_we,
  input wire logic dp_cy,
  input wire logic dp_ac,
  input wire logic dp_ov,
  input wire logic dp_flags_we,
  input wire logic dp_bit_sel_aux,
  input wire logic [2:0] dp_bit_idx,
  input wire logic dp_bit_val,
  input wire logic dp_pop_to_aux,
  // Datapath views
  output logic [7:0] main_operand_q,
  output logic [7:0] aux_operand_q,
  output logic [7:0] flags_q,
  output logic [7:0] sp_q,
  output logic bit_test_q,
  output logic [7:0] bank_base_q,
  // Internal data memory port
  output logic mem_we,
  output logic mem_re,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  logic [7:0] main_operand_reg;
  logic [7:0] aux_operand_reg;
  logic [7:0] cpu_flags_reg;
  logic [7:0] stack_top_ptr;
  logic ack_reg;
  logic err_reg;
  logic [7:0] rdata_reg;
  logic bit_test_reg;
  logic bus_req;
  logic bus_wr;
  logic hit;
  logic wr_main;
  logic wr_aux;
  logic wr_flags;
  logic wr_sp;
  logic parity_next;
  logic [7:0] main_next;

  ccr_stack_if st();

  function automatic logic [7:0] set_bit(input logic [7:0] v,
      input logic [2:0] idx, input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    set_bit = r;
  endfunction : set_bit

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = a == `CCR_OFF_MAIN || a == `CCR_OFF_AUX ||
      a == `CCR_OFF_FLAGS || a == `CCR_OFF_STACK;
  endfunction : reg_hit

  // Single-cycle answer; ack drops the cycle after it was given
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign hit = reg_hit(wb_adr_i);
  assign bus_wr = bus_req && wb_we_i && wb_sel_i && hit;
  assign wr_main = bus_wr && wb_adr_i == `CCR_OFF_MAIN;
  assign wr_aux = bus_wr && wb_adr_i == `CCR_OFF_AUX;
  assign wr_flags = bus_wr && wb_adr_i == `CCR_OFF_FLAGS;
  assign wr_sp = bus_wr && wb_adr_i == `CCR_OFF_STACK;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && hit;
      err_reg <= bus_req && !hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `CCR_RST_VAL;
    end else if (bus_req) begin
      case (wb_adr_i)
        `CCR_OFF_MAIN: rdata_reg <= main_operand_reg;
        `CCR_OFF_AUX: rdata_reg <= aux_operand_reg;
        `CCR_OFF_FLAGS: rdata_reg <= cpu_flags_reg;
        `CCR_OFF_STACK: rdata_reg <= stack_top_ptr;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // Accumulator: bus write wins over datapath in the same cycle
  always_comb begin
    main_next = main_operand_reg;
    if (dp_op == ccr_pkg::CCR_OP_BIT && !dp_bit_sel_aux) begin
      main_next = set_bit(main_operand_reg, dp_bit_idx, dp_bit_val);
    end else if (st.pop_valid && !dp_pop_to_aux) begin
      main_next = mem_rdata;
    end else if (dp_main_we) begin
      main_next = dp_main_wdata;
    end
    if (wr_main) begin
      main_next = wb_dat_i;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_operand_reg <= `CCR_RST_VAL;
    end else begin
      main_operand_reg <= main_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_operand_reg <= `CCR_RST_VAL;
    end else if (wr_aux) begin
      aux_operand_reg <= wb_dat_i;
    end else if (dp_op == ccr_pkg::CCR_OP_BIT && dp_bit_sel_aux) begin
      aux_operand_reg <= set_bit(aux_operand_reg, dp_bit_idx,
        dp_bit_val);
    end else if (st.pop_valid && dp_pop_to_aux) begin
      aux_operand_reg <= mem_rdata;
    end else if (dp_op == ccr_pkg::CCR_OP_MULDIV && dp_aux_we) begin
      aux_operand_reg <= dp_aux_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_test_reg <= 1'b0;
    end else if (dp_op == ccr_pkg::CCR_OP_BIT) begin
      bit_test_reg <= dp_bit_sel_aux ? aux_operand_reg[dp_bit_idx] :
        main_operand_reg[dp_bit_idx];
    end
  end

  // Parity follows the accumulator value that is being stored
  assign parity_next = ^main_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_flags_reg <= `CCR_RST_VAL;
    end else if (wr_flags) begin
      cpu_flags_reg <= {wb_dat_i[7:1], parity_next};
    end else begin
      if (dp_flags_we) begin
        cpu_flags_reg[`CCR_BIT_CY] <= dp_cy;
        cpu_flags_reg[`CCR_BIT_AC] <= dp_ac;
        cpu_flags_reg[`CCR_BIT_OV] <= dp_ov;
      end
      cpu_flags_reg[`CCR_BIT_P] <= parity_next;
    end
  end

  // Pointer stays 8 bits: the stack wraps inside internal memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_top_ptr <= `CCR_RST_VAL;
    end else if (wr_sp) begin
      stack_top_ptr <= wb_dat_i;
    end else if (st.sp_inc) begin
      stack_top_ptr <= stack_top_ptr + 8'h01;
    end else if (st.sp_dec) begin
      stack_top_ptr <= stack_top_ptr - 8'h01;
    end
  end

  assign st.push = dp_op == ccr_pkg::CCR_OP_PUSH;
  assign st.pop = dp_op == ccr_pkg::CCR_OP_POP;
  assign st.sp = stack_top_ptr;
  assign st.wdata = main_operand_reg;

  ccr_stack_eng u_stack (
    .clk(clk),
    .rst(rst),
    .st(st)
  );

  assign mem_we = st.mem_we;
  assign mem_re = st.mem_re;
  assign mem_addr = st.mem_addr;
  assign mem_wdata = st.mem_wdata;

  assign main_operand_q = main_operand_reg;
  assign aux_operand_q = aux_operand_reg;
  assign flags_q = cpu_flags_reg;
  assign sp_q = stack_top_ptr;
  assign bit_test_q = bit_test_reg;
  // Bank base is bank number times eight bytes
  assign bank_base_q = {3'h0, cpu_flags_reg[`CCR_BIT_RS1],
    cpu_flags_reg[`CCR_BIT_RS0], 3'h0};

  sequence bus_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && !ack_reg;
  endsequence

  main_write_a: assert property (@(posedge clk) disable iff (rst)
    bus_write_s and (wb_adr_i == 8'hE0) |=> main_operand_reg ==
    $past(wb_dat_i))
    else $error("accumulator bus write lost");
  aux_write_a: assert property (@(posedge clk) disable iff (rst)
    bus_write_s and (wb_adr_i == 8'hF0) |=> aux_operand_reg ==
    $past(wb_dat_i))
    else $error("auxiliary bus write lost");
  sp_write_a: assert property (@(posedge clk) disable iff (rst)
    bus_write_s and (wb_adr_i == 8'h81) |=> stack_top_ptr ==
    $past(wb_dat_i))
    else $error("stack pointer bus write lost");
  parity_track_a: assert property (@(posedge clk) disable iff (rst)
    cpu_flags_reg[0] == ^main_operand_reg)
    else $error("parity flag mismatch");
  push_addr_a: assert property (@(posedge clk) disable iff (rst)
    mem_we |-> mem_addr == stack_top_ptr + 8'h01 &&
    mem_wdata == main_operand_reg ##1 stack_top_ptr ==
    $past(stack_top_ptr) + 8'h01 || $past(wr_sp))
    else $error("push address or increment wrong");
  pop_addr_a: assert property (@(posedge clk) disable iff (rst)
    mem_re |-> mem_addr == stack_top_ptr)
    else $error("pop address wrong");
  user_flag_a: assert property (@(posedge clk) disable iff (rst)
    !wr_flags |=> $stable(cpu_flags_reg[5]))
    else $error("user flag changed without write");
  bank_base_a: assert property (@(posedge clk) disable iff (rst)
    bank_base_q == 8'(cpu_flags_reg[4:3]) * 8'h08)
    else $error("bank base mismatch");
  ack_once_a: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : ccr_core_regs
`default_nettype wire

// file: sim/ccr_core_regs_tb.sv
// Self-checking bench for the core register file
`timescale 1ns/1ps
`default_nettype none
module ccr_core_regs_tb;
  // Clock, reset and bus master
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sel = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [7:0] dat = 8'h00;
  // Datapath drive
  ccr_pkg::ccr_op_t op = ccr_pkg::CCR_OP_NONE;
  logic [7:0] mwd = 8'h00;
  logic [7:0] awd = 8'h00;
  logic [7:0] rdat = 8'h00;
  logic mwe = 1'b0;
  logic awe = 1'b0;
  logic fwe = 1'b0;
  logic [2:0] cao = 3'h0;
  logic bsel = 1'b0;
  logic [2:0] bidx = 3'h0;
  logic bval = 1'b0;
  logic p2a = 1'b0;
  // Observed outputs
  logic [7:0] dat_o, main_q, aux_q, flags_q, sp_q, bank_q, m_addr, m_wdata;
  logic ack, err, bit_q, m_we, m_re;
  // Model state and bookkeeping
  logic [7:0] acc = 8'h00;
  logic [7:0] aux = 8'h00;
  logic [7:0] sp = 8'h00;
  logic [7:0] fl = 8'h00;
  logic [7:0] q, v, a;
  logic e;
  int fails = 0;
  int total_checks = 0;
  int seed = 55;
  int cycles = 0;
  logic [7:0] regs [4] = '{8'h81, 8'hD0, 8'hE0, 8'hF0};

  always #12.5 clk = ~clk;

  ccr_core_regs u_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .dp_op(op), .dp_main_wdata(mwd),
    .dp_main_we(mwe), .dp_aux_wdata(awd), .dp_aux_we(awe),
    .dp_cy(cao[2]), .dp_ac(cao[1]), .dp_ov(cao[0]), .dp_flags_we(fwe),
    .dp_bit_sel_aux(bsel), .dp_bit_idx(bidx), .dp_bit_val(bval),
    .dp_pop_to_aux(p2a), .main_operand_q(main_q), .aux_operand_q(aux_q),
    .flags_q(flags_q), .sp_q(sp_q), .bit_test_q(bit_q),
    .bank_base_q(bank_q), .mem_we(m_we), .mem_re(m_re), .mem_addr(m_addr),
    .mem_wdata(m_wdata), .mem_rdata(rdat)
  );

  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction : rnd

  // Parity is never stored in the model, always derived
  function automatic logic [7:0] expect_of(input logic [7:0] ad);
    case (ad)
      8'h81: return sp;
      8'hD0: return {fl[7:1], ^acc};
      8'hE0: return acc;
      default: return aux;
    endcase
  endfunction : expect_of

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ack or error is taken at the rising edge; without either, only the bench timeout ends a wait
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d,
      output logic [7:0] rq, output logic re);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rq = dat_o;
    re = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    wb(1'b1, ad, d, q, e);
    if (sel) begin
      case (ad)
        8'h81: sp = d;
        8'hD0: fl = d;
        8'hE0: acc = d;
        default: aux = d;
      endcase
    end
  endtask : wr

  task automatic rdchk(input logic [7:0] ad);
    wb(1'b0, ad, 8'h00, q, e);
    chk(q, expect_of(ad));
  endtask : rdchk

  task automatic idle();
    @(posedge clk);
    op <= ccr_pkg::CCR_OP_NONE;
    mwe <= 1'b0;
    awe <= 1'b0;
    fwe <= 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdat <= rnd();
    foreach (regs[i]) rdchk(regs[i]);
    chk(bank_q, 8'h00);
    wb(1'b1, 8'hE1, 8'h5A, q, e);
    chk({7'h00, e}, 8'h01);
    // Byte select dropped now and then: acked, but must not land
    for (int i = 0; i < 24; i++) begin
      sel <= (rnd() & 8'h03) != 8'h00;
      a = regs[rnd() & 8'h03];
      wr(a, rnd());
      rdchk(a);
      chk({7'h00, flags_q[0]}, {7'h00, ^acc});
      chk(bank_q, {3'h0, fl[4:3], 3'h0});
    end
    sel <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      q = rnd();
      @(posedge clk);
      op <= i[0] ? ccr_pkg::CCR_OP_MULDIV : ccr_pkg::CCR_OP_ALU;
      cao <= v[2:0];
      mwd <= v;
      awd <= q;
      mwe <= 1'b1;
      awe <= 1'b1;
      fwe <= !i[0];
      idle();
      acc = v;
      if (i[0]) aux = q;
      else fl = {v[2], v[1], fl[5:3], v[0], fl[1:0]};
      chk(main_q, acc);
      chk(aux_q, aux);
      chk(flags_q, {fl[7:1], ^acc});
    end
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      @(posedge clk);
      op <= ccr_pkg::CCR_OP_BIT;
      bsel <= i[3];
      bidx <= i[2:0];
      bval <= v[0];
      idle();
      // Test output holds the bit as it was before the set
      e = i[3] ? aux[i[2:0]] : acc[i[2:0]];
      if (i[3]) aux[i[2:0]] = v[0];
      else acc[i[2:0]] = v[0];
      chk(i[3] ? aux_q : main_q, i[3] ? aux : acc);
      chk({7'h00, bit_q}, {7'h00, e});
    end
    // Start near the top so both pushes and pops wrap the pointer
    wr(8'h81, 8'hFE);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      op <= ccr_pkg::CCR_OP_PUSH;
      @(negedge clk);
      chk({7'h00, m_we}, 8'h01);
      chk(m_addr, sp + 8'h01);
      chk(m_wdata, acc);
      idle();
      sp = sp + 8'h01;
      chk(sp_q, sp);
    end
    for (int i = 0; i < 2; i++) begin
      v = rnd();
      @(posedge clk);
      op <= ccr_pkg::CCR_OP_POP;
      p2a <= i[0];
      @(negedge clk);
      chk({7'h00, m_re}, 8'h01);
      chk(m_addr, sp);
      @(posedge clk);
      op <= ccr_pkg::CCR_OP_NONE;
      rdat <= v;
      @(posedge clk);
      rdat <= ~v;
      @(negedge clk);
      if (i[0]) aux = v;
      else acc = v;
      sp = sp - 8'h01;
      chk(i[0] ? aux_q : main_q, v);
      chk(sp_q, sp);
      repeat (2) @(posedge clk);
    end
    foreach (regs[i]) rdchk(regs[i]);
    close_out();
  end
endmodule : ccr_core_regs_tb
`default_nettype wire
